// file: design/sfl_pkg.sv
// Constants and types for the serial flash status and read command engine
package sfl_pkg;
    // Opcodes
    localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_RDSR1 = 8'h05;
    localparam logic [7:0] OP_RDSR2 = 8'h35;
    localparam logic [7:0] OP_RDSR3 = 8'h15;
    localparam logic [7:0] OP_WRSR1 = 8'h01;
    localparam logic [7:0] OP_WRSR2 = 8'h31;
    localparam logic [7:0] OP_WRSR3 = 8'h11;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DUAL = 8'h3b;
    localparam logic [7:0] OP_QUAD = 8'h6b;
    // Status field positions and writable masks
    localparam int SR1_BUSY = 0;
    localparam int SR1_WEL = 1;
    localparam int SR2_SRL = 0;
    localparam int SR2_QE = 1;
    localparam int SR2_LB = 2;
    localparam logic [7:0] SR1_WMASK = 8'hfc;
    localparam logic [7:0] SR2_WMASK = 8'h47;
    localparam logic [7:0] SR2_VSTICKY = 8'h05;
    localparam logic [7:0] SR2_NVSTICKY = 8'h04;
    localparam logic [7:0] SR3_VAL = 8'h00;
    // Values after power-on and the byte sent on buffer underrun
    localparam logic [7:0] NV_SR1_RST = 8'h00;
    localparam logic [7:0] NV_SR2_RST = 8'h00;
    localparam logic [7:0] UNDERRUN_BYTE = 8'hff;
    // Bit counts within a frame
    localparam logic [4:0] CNT_BYTE = 5'd8;
    localparam logic [4:0] CNT_WORD = 5'd16;
    localparam logic [4:0] CNT_ADDR_LAST = 5'd23;
    localparam logic [4:0] CNT_BYTE_LAST = 5'd7;
    localparam logic [4:0] CNT_SAT = 5'd17;
    // Timing
    localparam int CLK_NS = 100;
    localparam int STATUS_WRITE_CYCLE_TIME_US = 5000;
    localparam int VOLATILE_REFRESH_TIME_US = 50;
    localparam int VOLATILE_REFRESH_CYC = VOLATILE_REFRESH_TIME_US * 1000 / CLK_NS;
    localparam int ADDR_W = 24;

    typedef enum logic [6:0] {
        ST_CMD = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_DUMMY = 7'b0000100,
        ST_DATA = 7'b0001000,
        ST_STAT = 7'b0010000,
        ST_WDAT = 7'b0100000,
        ST_IGN = 7'b1000000
    } sfl_state_type;

    typedef enum logic [1:0] {
        MD_SINGLE = 2'b00,
        MD_DUAL = 2'b01,
        MD_QUAD = 2'b10
    } sfl_mode_type;

    // Pin sample bundle
    typedef struct packed {
        logic [3:0] io;
        logic sclk;
        logic cs_n;
    } sfl_pin_type;
endpackage

// file: design/sfl_core.sv
// Serial flash status register and read command engine
`timescale 1ns/1ns
`default_nettype none
module sfl_core
    import sfl_pkg::*;
#(
    parameter int TW_CYC = STATUS_WRITE_CYCLE_TIME_US * 1000 / CLK_NS
)(
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_out,
    output logic [23:0] array_addr_out,
    input wire logic [7:0] array_data_in,
    input wire logic array_valid_in,
    output logic array_ready_out,
    input wire logic ext_busy_in,
    input wire logic soft_rst_in,
    output logic busy_out
);
    // Merge a written byte under a mask, keeping sticky ones
    function automatic logic [7:0] sfl_merge(input logic [7:0] o, input logic [7:0] n,
                                             input logic [7:0] m, input logic [7:0] s);
        sfl_merge = (o & ~m) | (n & m) | (o & s);
    endfunction

    // Next shift value and line levels for one output clock
    function automatic logic [11:0] sfl_shout(input logic [7:0] b, input sfl_mode_type md);
        case (md)
            MD_DUAL: sfl_shout = {b[5:0], 2'b00, 2'b00, b[7], b[6]};
            MD_QUAD: sfl_shout = {b[3:0], 4'h0, b[7:4]};
            default: sfl_shout = {b[6:0], 1'b0, 2'b00, b[7], 1'b0};
        endcase
    endfunction

    sfl_pin_type p1_r, p2_r, p3_r, pf_r, pf_nxt;
    sfl_state_type st_r, st_nxt;
    sfl_mode_type mode_r, mode_nxt;
    logic [7:0] op_r, op_nxt, osh_r, osh_nxt, bt, din_byte, sel_sr, sr1_vis;
    logic [23:0] sh_r, sh_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [2:0] ocnt_r, ocnt_nxt, olast;
    logic [3:0] io_r, io_nxt, oe_r, oe_nxt;
    logic [11:0] so;
    logic rise, fall, cs_rise, op_ev, addr_ld, pop, busy_any;
    logic [7:0] sr1v_r, sr1v_nxt, sr2v_r, sr2v_nxt, nv1_r, nv1_nxt, nv2_r, nv2_nxt, w0, w1;
    logic wel_r, wel_nxt, vperm_r, vperm_nxt, busy_r, busy_nxt, wr_ok, wr1, wr2;
    logic [19:0] tmr_r, tmr_nxt;
    logic [7:0] b0_r, b0_nxt, b1_r, b1_nxt;
    logic [1:0] bc_r, bc_nxt;
    logic [23:0] fa_r, fa_nxt;
    logic rdy_r, rdy_nxt, acc, act_nxt;

    // Pin filter: a change counts once stages two and three agree
    assign pf_nxt = sfl_pin_type'((p2_r & ~(p2_r ^ p3_r)) | (pf_r & (p2_r ^ p3_r)));
    assign rise = pf_nxt.sclk & ~pf_r.sclk & ~pf_r.cs_n;
    assign fall = ~pf_nxt.sclk & pf_r.sclk & ~pf_r.cs_n;
    assign cs_rise = pf_nxt.cs_n & ~pf_r.cs_n;
    assign din_byte = {sh_r[6:0], pf_nxt.io[0]};
    assign busy_any = busy_r | ext_busy_in;
    assign sr1_vis = {sr1v_r[7:2], wel_r, busy_any};

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            p1_r <= '{io: 4'h0, sclk: 1'b0, cs_n: 1'b1};
            p2_r <= '{io: 4'h0, sclk: 1'b0, cs_n: 1'b1};
            p3_r <= '{io: 4'h0, sclk: 1'b0, cs_n: 1'b1};
            pf_r <= '{io: 4'h0, sclk: 1'b0, cs_n: 1'b1};
        end
        else
        begin
            p1_r <= '{io: io_in, sclk: sclk_in, cs_n: cs_n_in};
            p2_r <= p1_r;
            p3_r <= p2_r;
            pf_r <= pf_nxt;
        end
    end

    // Selected status byte for reads
    always_comb
    begin
        if (op_r == OP_RDSR1)
            sel_sr = sr1_vis;
        else if (op_r == OP_RDSR2)
            sel_sr = sr2v_r;
        else
            sel_sr = SR3_VAL;
    end

    // Command sequencer: opcode, address, dummy, data out
    always_comb
    begin
        st_nxt = st_r;
        op_nxt = op_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        mode_nxt = mode_r;
        osh_nxt = osh_r;
        ocnt_nxt = ocnt_r;
        io_nxt = io_r;
        oe_nxt = oe_r;
        op_ev = 1'b0;
        addr_ld = 1'b0;
        pop = 1'b0;
        bt = osh_r;
        so = sfl_shout(osh_r, mode_r);
        olast = (mode_r == MD_QUAD) ? 3'd1 : (mode_r == MD_DUAL) ? 3'd3 : 3'd7;
        if (pf_r.cs_n)
        begin
            st_nxt = ST_CMD;
            cnt_nxt = 5'd0;
            ocnt_nxt = 3'd0;
            oe_nxt = 4'h0;
        end
        else if (rise)
        begin
            sh_nxt = {sh_r[22:0], pf_nxt.io[0]}; // Wide enough for a full address
            cnt_nxt = cnt_r + 5'd1;
            case (st_r)
                ST_CMD:
                begin
                    if (cnt_r == CNT_BYTE_LAST)
                    begin
                        op_nxt = din_byte;
                        op_ev = 1'b1;
                        cnt_nxt = 5'd0;
                        mode_nxt = (din_byte == OP_DUAL) ? MD_DUAL : (din_byte == OP_QUAD) ? MD_QUAD : MD_SINGLE;
                        if (din_byte == OP_RDSR1 || din_byte == OP_RDSR2 || din_byte == OP_RDSR3)
                            st_nxt = ST_STAT;
                        else if (din_byte == OP_WRSR1 || din_byte == OP_WRSR2 || din_byte == OP_WRSR3)
                            st_nxt = ST_WDAT;
                        else if ((din_byte == OP_READ || din_byte == OP_FAST || din_byte == OP_DUAL) && !busy_any)
                            st_nxt = ST_ADDR;
                        else if (din_byte == OP_QUAD && !busy_any && sr2v_r[SR2_QE])
                            st_nxt = ST_ADDR;
                        else
                        begin
                            st_nxt = ST_IGN;
                            cnt_nxt = CNT_BYTE;
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (cnt_r == CNT_ADDR_LAST)
                    begin
                        addr_ld = 1'b1;
                        cnt_nxt = 5'd0;
                        st_nxt = (op_r == OP_READ) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY:
                begin
                    if (cnt_r == CNT_BYTE_LAST)
                        st_nxt = ST_DATA;
                end
                ST_WDAT:
                begin
                    if (cnt_r == CNT_SAT)
                        cnt_nxt = cnt_r;
                end
                default:
                    cnt_nxt = cnt_r;
            endcase
        end
        else if (fall && st_r == ST_STAT)
        begin
            bt = (ocnt_r == 3'd0) ? sel_sr : osh_r;
            io_nxt = {2'b00, bt[7], 1'b0};
            oe_nxt = 4'h2;
            osh_nxt = {bt[6:0], 1'b0};
            ocnt_nxt = ocnt_r + 3'd1;
        end
        else if (fall && st_r == ST_DATA)
        begin
            pop = (ocnt_r == 3'd0);
            bt = !pop ? osh_r : (bc_r != 2'd0) ? b0_r : UNDERRUN_BYTE;
            so = sfl_shout(bt, mode_r);
            osh_nxt = so[11:4];
            io_nxt = so[3:0];
            oe_nxt = (mode_r == MD_QUAD) ? 4'hf : (mode_r == MD_DUAL) ? 4'h3 : 4'h2;
            ocnt_nxt = (ocnt_r == olast) ? 3'd0 : ocnt_r + 3'd1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            st_r <= ST_CMD;
            op_r <= 8'h00;
            sh_r <= 24'h000000;
            cnt_r <= 5'd0;
            mode_r <= MD_SINGLE;
            osh_r <= 8'h00;
            ocnt_r <= 3'd0;
            io_r <= 4'h0;
            oe_r <= 4'h0;
        end
        else
        begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
            osh_r <= osh_nxt;
            ocnt_r <= ocnt_nxt;
            io_r <= io_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Status write decode at chip select rise
    assign wr_ok = cs_rise && st_r == ST_WDAT && !busy_any &&
                   (cnt_r == CNT_BYTE || (cnt_r == CNT_WORD && op_r == OP_WRSR1));
    assign w0 = (cnt_r == CNT_WORD) ? sh_r[15:8] : sh_r[7:0];
    assign w1 = sh_r[7:0];
    assign wr1 = op_r == OP_WRSR1;
    assign wr2 = (wr1 && cnt_r == CNT_WORD) || op_r == OP_WRSR2;

    // Status registers, latch, permission and write cycle timer
    always_comb
    begin
        sr1v_nxt = sr1v_r;
        sr2v_nxt = sr2v_r;
        nv1_nxt = nv1_r;
        nv2_nxt = nv2_r;
        wel_nxt = wel_r;
        vperm_nxt = vperm_r;
        busy_nxt = busy_r;
        tmr_nxt = tmr_r;
        if (op_ev && op_nxt != OP_VWREN && op_nxt != OP_WRSR1 && op_nxt != OP_WRSR2 && op_nxt != OP_WRSR3)
            vperm_nxt = 1'b0;
        if (cs_rise && st_r == ST_IGN && cnt_r == CNT_BYTE)
        begin
            if (op_r == OP_WRITE_ENABLE_CMD && !busy_any)
                wel_nxt = 1'b1;
            else if (op_r == OP_WRDI && !busy_any)
                wel_nxt = 1'b0;
            else if (op_r == OP_VWREN)
                vperm_nxt = 1'b1;
        end
        if (cs_rise && st_r == ST_WDAT)
            vperm_nxt = 1'b0;
        if (wr_ok && wel_r)
        begin
            nv1_nxt = wr1 ? sfl_merge(nv1_r, w0, SR1_WMASK, 8'h00) : nv1_r;
            nv2_nxt = wr2 ? sfl_merge(nv2_r, (wr1 ? w1 : w0), SR2_WMASK, SR2_NVSTICKY) : nv2_r;
            sr1v_nxt = nv1_nxt;
            sr2v_nxt = nv2_nxt;
            busy_nxt = 1'b1;
            tmr_nxt = 20'(TW_CYC);
        end
        else if (wr_ok && vperm_r)
        begin
            sr1v_nxt = wr1 ? sfl_merge(sr1v_r, w0, SR1_WMASK, 8'h00) : sr1v_r;
            sr2v_nxt = wr2 ? sfl_merge(sr2v_r, (wr1 ? w1 : w0), SR2_WMASK, SR2_VSTICKY) : sr2v_r;
        end
        if (busy_r)
        begin
            tmr_nxt = tmr_r - 20'd1;
            if (tmr_r == 20'd1)
            begin
                busy_nxt = 1'b0;
                wel_nxt = 1'b0;
            end
        end
        if (soft_rst_in)
        begin
            sr1v_nxt = nv1_r;
            sr2v_nxt = nv2_r;
            wel_nxt = 1'b0;
            vperm_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sr1v_r <= NV_SR1_RST;
            sr2v_r <= NV_SR2_RST;
            nv1_r <= NV_SR1_RST;
            nv2_r <= NV_SR2_RST;
            wel_r <= 1'b0;
            vperm_r <= 1'b0;
            busy_r <= 1'b0;
            tmr_r <= 20'd0;
        end
        else
        begin
            sr1v_r <= sr1v_nxt;
            sr2v_r <= sr2v_nxt;
            nv1_r <= nv1_nxt;
            nv2_r <= nv2_nxt;
            wel_r <= wel_nxt;
            vperm_r <= vperm_nxt;
            busy_r <= busy_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // Two-entry read buffer between array and shifter
    assign acc = array_valid_in & rdy_r;
    assign act_nxt = (st_nxt == ST_DATA || st_nxt == ST_DUMMY) && !pf_r.cs_n;
    always_comb
    begin
        b0_nxt = b0_r;
        b1_nxt = b1_r;
        bc_nxt = bc_r;
        fa_nxt = fa_r;
        if (pop && bc_r != 2'd0)
        begin
            b0_nxt = b1_r;
            bc_nxt = bc_r - 2'd1;
        end
        if (acc)
        begin
            fa_nxt = fa_r + 24'd1;
            if (bc_nxt == 2'd0)
                b0_nxt = array_data_in;
            else
                b1_nxt = array_data_in;
            bc_nxt = bc_nxt + 2'd1;
        end
        if (addr_ld)
        begin
            fa_nxt = {sh_r[22:0], pf_nxt.io[0]};
            bc_nxt = 2'd0;
        end
        else if (pf_r.cs_n)
            bc_nxt = 2'd0;
        rdy_nxt = act_nxt && bc_nxt != 2'd2;
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            b0_r <= 8'h00;
            b1_r <= 8'h00;
            bc_r <= 2'd0;
            fa_r <= 24'h000000;
            rdy_r <= 1'b0;
        end
        else
        begin
            b0_r <= b0_nxt;
            b1_r <= b1_nxt;
            bc_r <= bc_nxt;
            fa_r <= fa_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign io_out = io_r;
    assign io_oe_out = oe_r;
    assign array_addr_out = fa_r;
    assign array_ready_out = rdy_r;
    assign busy_out = busy_r;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    AST_VPERM_CLR: assert property (op_ev && (op_nxt == OP_READ || op_nxt == OP_RDSR1) |=> !vperm_r)
        else $error("volatile permission survived other opcode");
    AST_VWREN_WEL: assert property (cs_rise && st_r == ST_IGN && op_r == OP_VWREN && !busy_r |=> wel_r == $past(wel_r))
        else $error("volatile enable changed latch");
    AST_RO_BITS: assert property ((sr2v_r & ~SR2_WMASK) == 8'h00 && (sr1v_r & ~SR1_WMASK) == 8'h00)
        else $error("read-only status bit changed");
    AST_LB_STICKY: assert property ($past(nv2_r[SR2_LB]) |-> nv2_r[SR2_LB] && !$fell(sr2v_r[SR2_LB]))
        else $error("security lock cleared");
    AST_NOPERM: assert property (wr_ok && !wel_r && !vperm_r |=> $stable(sr1v_r) && $stable(sr2v_r) && !busy_r)
        else $error("unpermitted status write took effect");
    AST_BUSY_NV: assert property (wr_ok && wel_r |=> busy_r && tmr_r == 20'(TW_CYC))
        else $error("busy cycle not started");
    AST_WEL_END: assert property (busy_r && tmr_r == 20'd1 |=> !busy_r && !wel_r)
        else $error("latch not cleared at cycle end");
    AST_VOL_WR: assert property (wr_ok && !wel_r && vperm_r |=> !busy_r ##1 !busy_r)
        else $error("volatile write raised busy");
    AST_READ_REJ: assert property (op_ev && op_nxt == OP_READ && busy_any |=> st_r == ST_IGN [*2])
        else $error("read accepted while busy");
    AST_QUAD_QE: assert property (st_r == ST_ADDR && mode_r == MD_QUAD |-> $past(sr2v_r[SR2_QE]))
        else $error("quad read without quad enable");
    AST_CS_END: assert property (pf_r.cs_n |=> oe_r == 4'h0 && st_r == ST_CMD)
        else $error("outputs driven after deselect");

    COV_NV_WRITE: cover property (wr_ok && wel_r ##1 busy_r);
    COV_STAT_READ: cover property (st_r == ST_STAT && fall && ocnt_r == 3'd7);
    COV_QUAD_DATA: cover property (st_r == ST_DATA && mode_r == MD_QUAD && pop);
    COV_VOL_WRITE: cover property (wr_ok && vperm_r && !wel_r);
endmodule
`default_nettype wire

// file: test/sfl_host.sv
// SPI host model: chip select, serial clock, data in and the wire level of every data line
`timescale 1ns/1ns
`default_nettype none
module sfl_host
(
    input wire logic sys_clk_in,
    input wire logic [3:0] io_out_in,
    input wire logic [3:0] io_oe_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic [3:0] io_in_out,
    output logic oe_seen_out
);
    logic di_r;
    logic tgl_r = 1'b0;
    logic [3:0] smp;

    // Idle levels at time zero
    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        di_r = 1'b0;
    end

    // Undriven lines 1 to 3 show a pattern that flips every cycle; undriven line 0 carries data in
    always @(posedge sys_clk_in) tgl_r <= ~tgl_r;
    assign io_in_out = (io_oe_in & io_out_in) | (~io_oe_in & {tgl_r, tgl_r, tgl_r, di_r});

    // Records whether the device drove any line during the frame
    always @(posedge sys_clk_in) oe_seen_out <= cs_n_out ? 1'b0 : (oe_seen_out | (|io_oe_in));

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask

    task automatic start();
        cs_n_out <= 1'b0;
        tick(4);
    endtask

    // Lowers the clock, then deselects with a long gap
    task automatic fin(output logic seen);
        sclk_out <= 1'b0;
        tick(4);
        seen = oe_seen_out;
        cs_n_out <= 1'b1;
        tick(8);
    endtask

    // One 800 ns clock period, data in held well past the rise
    task automatic bit_cyc(input logic di);
        sclk_out <= 1'b0;
        tick(2);
        di_r <= di;
        tick(2);
        sclk_out <= 1'b1;
        tick(4);
        smp = io_in_out;
    endtask

    // One byte: md 0 single, 1 dual, 2 quad
    task automatic xfer(input logic [7:0] tx, input int md, output logic [7:0] rx);
        int i;
        rx = 8'h00;
        for (i = 0; i < (8 >> md); i++)
        begin
            bit_cyc(tx[7 - i]);
            case (md)
                0: rx = {rx[6:0], smp[1]};
                1: rx = {rx[5:0], smp[1:0]};
                default: rx = {rx[3:0], smp};
            endcase
        end
    endtask
endmodule
`default_nettype wire

// file: test/test_serial_flash_status_and_read_cmds.sv
// Self-checking bench for the status and read command engine
`timescale 1ns/1ns
`default_nettype none
module test_serial_flash_status_and_read_cmds;
    import sfl_pkg::*;
    localparam int TW = 1000;
    logic sys_clk, arst_n, ext_busy, soft_rst, arr_valid, arr_ready, busy;
    wire logic cs_n, sclk, oe_seen;
    wire logic [3:0] io_in;
    logic [3:0] io_out, io_oe;
    logic [23:0] arr_addr;
    logic [7:0] arr_data, m1, m2, nv1, nv2;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int bcnt = 0;

    // Array content derived from the address
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h3c;
    endfunction

    assign arr_data = mem(arr_addr);

    sfl_core #(.TW_CYC(TW)) dut (.sys_clk_in(sys_clk), .arst_n_in(arst_n), .cs_n_in(cs_n), .sclk_in(sclk),
        .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe), .array_addr_out(arr_addr),
        .array_data_in(arr_data), .array_valid_in(arr_valid), .array_ready_out(arr_ready),
        .ext_busy_in(ext_busy), .soft_rst_in(soft_rst), .busy_out(busy));

    sfl_host host (.sys_clk_in(sys_clk), .io_out_in(io_out), .io_oe_in(io_oe), .cs_n_out(cs_n),
        .sclk_out(sclk), .io_in_out(io_in), .oe_seen_out(oe_seen));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Array stalls, never two cycles running; busy cycle counter; hang limit
    always @(posedge sys_clk)
    begin
        arr_valid <= ~arr_valid | 1'($urandom % 2);
        if (busy === 1'b1) bcnt <= bcnt + 1;
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            n_errors++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Command frame with up to two data bytes
    task automatic frame(input logic [7:0] op, input logic [7:0] d0, input logic [7:0] d1, input int nb);
        logic [7:0] rx;
        logic s;
        host.start();
        host.xfer(op, 0, rx);
        if (nb > 0) host.xfer(d0, 0, rx);
        if (nb > 1) host.xfer(d1, 0, rx);
        host.fin(s);
    endtask

    // Status read, two repeats in one frame
    task automatic rdsr(input logic [7:0] op, input logic [7:0] exp);
        logic [7:0] rx;
        logic s;
        int k;
        host.start();
        host.xfer(op, 0, rx);
        for (k = 0; k < 2; k++)
        begin
            host.xfer(8'h00, 0, rx);
            chk("status", rx, exp);
        end
        host.fin(s);
    endtask

    // Array read of three bytes from a random address
    task automatic rd(input logic [7:0] op, input int md, input int dum, input logic ok);
        logic [7:0] rx;
        logic s;
        logic [23:0] a;
        int k;
        a = 24'($urandom);
        host.start();
        host.xfer(op, 0, rx);
        for (k = 2; k >= 0; k--) host.xfer(a[8 * k +: 8], 0, rx);
        if (dum != 0) host.xfer(8'h00, 0, rx);
        for (k = 0; k < 3; k++)
        begin
            host.xfer(8'h00, md, rx);
            if (ok) chk("read data", rx, mem(a + 24'(k)));
        end
        host.fin(s);
        chk("read driven", {7'h0, s}, {7'h0, ok});
        chk("ready idle", {7'h0, arr_ready}, 8'h00);
    endtask

    // Waits out a self-timed write and checks its length
    task automatic wait_idle(input int b0);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000)
        begin
            @(posedge sys_clk);
            k++;
        end
        host.tick(2);
        chk("busy cycles", 8'(bcnt - b0 >= TW && bcnt - b0 <= TW + 8), 8'h01);
    endtask

    initial
    begin
        int b0;
        arst_n = 1'b0;
        ext_busy = 1'b0;
        soft_rst = 1'b0;
        arr_valid = 1'b0;
        void'($urandom(98));
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        host.tick(6);
        rdsr(OP_RDSR1, NV_SR1_RST);
        rdsr(OP_RDSR2, NV_SR2_RST);
        rdsr(OP_RDSR3, SR3_VAL);
        m1 = NV_SR1_RST;
        m2 = NV_SR2_RST;
        $display("test reset finished");
        frame(OP_WRSR1, 8'hff, 8'hff, 2);
        rdsr(OP_RDSR1, m1);
        cmd_write_enable_cmd();
        b0 = bcnt;
        frame(OP_WRSR1, 8'hff, 8'hff, 2);
        m1 = 8'hff & SR1_WMASK;
        m2 = 8'hff & SR2_WMASK;
        rd(OP_READ, 0, 0, 1'b0);
        rdsr(OP_RDSR1, m1 | 8'h03);
        wait_idle(b0);
        rdsr(OP_RDSR1, m1);
        rdsr(OP_RDSR2, m2);
        cmd_write_enable_cmd();
        b0 = bcnt;
        frame(OP_WRSR2, 8'h00, 8'h00, 1);
        wait_idle(b0);
        m2 = m2 & SR2_NVSTICKY;
        rdsr(OP_RDSR2, m2);
        nv1 = m1;
        nv2 = m2;
        $display("test stored write finished");
        b0 = bcnt;
        frame(OP_VWREN, 8'h00, 8'h00, 0);
        frame(OP_WRSR2, 8'h03, 8'h00, 1);
        m2 = 8'h03 | m2;
        rdsr(OP_RDSR1, m1);
        rdsr(OP_RDSR2, m2);
        chk("busy idle", 8'(bcnt - b0), 8'h00);
        frame(OP_VWREN, 8'h00, 8'h00, 0);
        frame(OP_WRSR2, 8'h00, 8'h00, 1);
        m2 = m2 & SR2_VSTICKY;
        rdsr(OP_RDSR2, m2);
        frame(OP_VWREN, 8'h00, 8'h00, 0);
        frame(OP_RDSR1, 8'h00, 8'h00, 0);
        frame(OP_WRSR1, 8'h00, 8'h00, 1);
        rdsr(OP_RDSR1, m1);
        $display("test volatile write finished");
        soft_rst <= 1'b1;
        host.tick(1);
        soft_rst <= 1'b0;
        host.tick(4);
        m1 = nv1;
        m2 = nv2;
        rdsr(OP_RDSR1, m1);
        rdsr(OP_RDSR2, m2);
        cmd_write_enable_cmd();
        b0 = bcnt;
        frame(OP_WRSR1, 8'h00, 8'h00, 1);
        wait_idle(b0);
        m1 = 8'h00;
        rdsr(OP_RDSR1, m1);
        rdsr(OP_RDSR2, m2);
        $display("test reset and short write finished");
        ext_busy <= 1'b1;
        host.tick(2);
        rdsr(OP_RDSR1, m1 | 8'h01);
        rd(OP_FAST, 0, 1, 1'b0);
        ext_busy <= 1'b0;
        rd(OP_QUAD, 2, 1, 1'b0);
        frame(OP_VWREN, 8'h00, 8'h00, 0);
        frame(OP_WRSR2, 8'h02, 8'h00, 1);
        rd(OP_READ, 0, 0, 1'b1);
        rd(OP_FAST, 0, 1, 1'b1);
        rd(OP_DUAL, 1, 1, 1'b1);
        rd(OP_QUAD, 2, 1, 1'b1);
        $display("test array reads finished");
        end_sim();
    end

    // Write enable, then confirm the latch is set
    task automatic cmd_write_enable_cmd();
        frame(OP_WRITE_ENABLE_CMD, 8'h00, 8'h00, 0);
        rdsr(OP_RDSR1, m1 | 8'h02);
    endtask
endmodule
`default_nettype wire
